/* File: hdl/wsf_defs.svh */
// Constants for the weigh mode and serial frame block.
// Assumes a 100 MHz clock and a 7-bit ASCII serial line.
// Behaviour
// - Zero key re-zeros only inside the zero band, 1.9% of full scale
// - Zero refused above band, in motion, or in over/underload
// - Gross/net key toggles display; gross and net lamps show mode
// - Tare in gross mode above half graduation stores tare, goes net
// - Negative or moving tare leaves mode and stored tare unchanged
// - With conversion enabled, unit key toggles demand_unit_field; lamps follow
// - Print key, or serial print when bidirectional, sends a demand frame
// - Reset starts in gross mode with gross lamp lit
// - Overload flagged above 105% of capacity
// - Legal setting: overload at 103% once zero captured 2%
// - Underload flagged below 400 graduations under zero
// - Net mode digits build fixed tare; enter applies, clear discards
// - Recall key shows current tare; recall lamp flashes meanwhile
// - Character is start, seven data, odd parity, stop
// - Every frame starts with start-of-text
// - Polarity is space for positive, minus for negative
// - Weight field seven characters, dummy zero option, leading spaces
// - ID field six digits, with ID and NO labels
// - Demand frames carry DEMAND_UNIT_FIELD and DEMAND_WEIGHMODE_FIELD fields
// - Continuous frames carry L/K and G/N characters
// - Every frame ends with carriage return then line feed
// - Status character reports highest priority condition
// - Field delimiters are never sent
// - Continuous frame after a display update that finds the builder idle and no print pending, fixed field order
// - Demand frame field order with spaces between fields
// - Demand output suppressed in motion, overload, negative gross in gross mode, check
`ifndef WSF_DEFS_SVH
`define WSF_DEFS_SVH
// Clock rate, line rate and recall flash half period in ms
`define WSF_CLK_HZ 32'h05f5e100
`define WSF_BAUD 32'h00002580
`define WSF_FLASH_MS 32'h000000fa
`define WSF_MS_PER_S 32'h000003e8
// Per-mille of full scale: band, overload, legal overload, capture
`define WSF_ZBAND_PM 11'h013
`define WSF_OVL_PM 11'h41a
`define WSF_OVL_LEGAL_PM 11'h406
`define WSF_CAPT_PM 11'h014
`define WSF_PERMIL 11'h3e8
`define WSF_UNDER_GRAD 24'h000190
// Pound to kilogram factor in 16-bit fraction
`define WSF_KG_MUL 41'h000_0000_741f
`define WSF_KG_SHIFT 16
// Entry length, stop bit slot, last frame indexes
`define WSF_ENT_MAX 3'h6
`define WSF_STOP_BIT 4'h9
`define WSF_LAST_CONT 5'h0d
`define WSF_LAST_DEM 5'h11
// Characters
`define WSF_C_STX 7'h02
`define WSF_C_LF 7'h0a
`define WSF_C_CR 7'h0d
`define WSF_C_SP 7'h20
`define WSF_C_MIN 7'h2d
`define WSF_C_DOT 7'h2e
`define WSF_C_0 7'h30
`define WSF_C_A 7'h41
`define WSF_C_B 7'h42
`define WSF_C_D 7'h44
`define WSF_C_G 7'h47
`define WSF_C_I 7'h49
`define WSF_C_K 7'h4b
`define WSF_C_L 7'h4c
`define WSF_C_M 7'h4d
`define WSF_C_N 7'h4e
`define WSF_C_O 7'h4f
`define WSF_C_R 7'h52
`define WSF_C_T 7'h54
`define WSF_C_Z 7'h5a
`endif

/* File: hdl/wsf_pkg.sv */
// Types for the weigh mode and serial frame block.
// Assumes wsf_defs.svh supplies the constants.
package wsf_pkg;
    typedef struct packed {
        logic zero;
        logic gn;
        logic tare;
        logic unit;
        logic prnt;
        logic recall;
        logic digit;
        logic enter;
        logic clear;
    } wsf_keys_t;
    typedef enum logic [3:0] {
        F_IDLE = 4'h1,
        F_ID = 4'h2,
        F_DEM = 4'h4,
        F_CONT = 4'h8
    } wsf_fst_t;
    typedef enum logic [1:0] {
        U_IDLE = 2'h1,
        U_SEND = 2'h2
    } wsf_ust_t;
    typedef struct packed {
        logic neg;
        logic kg;
        logic net;
        logic dz;
        logic [6:0] stat;
        logic [27:0] wd;
        logic [23:0] idd;
    } wsf_snap_t;
endpackage

/* File: hdl/wsf_top.sv */
// Weigh mode key handling, frame builder, FIFO and serial sender.
// Assumes keys are raw pins; datapath and config share CLK.
`timescale 1ns/1ps
`include "wsf_defs.svh"

module wsf_fifo #(
    parameter int W = 7,
    parameter int DEPTH = 32
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // Fill side
    input wire logic in_valid,
    input wire logic [W-1:0] in_data,
    output logic in_ready,
    // Drain side
    output logic out_valid,
    output logic [W-1:0] out_data,
    input wire logic out_ready
);
    localparam int AW = $clog2(DEPTH);
    typedef struct packed {
        logic [DEPTH-1:0][W-1:0] mem;
        logic [AW:0] wr;
        logic [AW:0] rd;
    } wsf_fifo_st_t;
    wsf_fifo_st_t s_r, s_nxt;

    // Pointers wrap only for a power-of-two depth
    if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad
        $error("fifo depth must be a power of two");
    end

    // Full when pointers differ only in the wrap bit
    assign out_valid = s_r.wr != s_r.rd;
    assign in_ready = s_r.wr != {~s_r.rd[AW], s_r.rd[AW-1:0]};
    assign out_data = s_r.mem[s_r.rd[AW-1:0]];

    // Push and pop
    always_comb begin
        s_nxt = s_r;
        if (in_valid && in_ready) begin
            s_nxt.mem[s_r.wr[AW-1:0]] = in_data;
            s_nxt.wr = s_r.wr + {{AW{1'b0}}, 1'b1};
        end
        if (out_valid && out_ready) begin
            s_nxt.rd = s_r.rd + {{AW{1'b0}}, 1'b1};
        end
    end

    // State register
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end
endmodule

module wsf_top #(
    parameter int BIT_CYCLES = `WSF_CLK_HZ / `WSF_BAUD,
    parameter int FLASH_CYCLES = `WSF_CLK_HZ / `WSF_MS_PER_S * `WSF_FLASH_MS,
    parameter int FIFO_DEPTH = 32
) (
    // Clock and reset
    input wire logic CLK,
    input wire logic RST_B,
    // Front-panel keys, raw pins, high while pressed
    input wire logic KEY_ZERO,
    input wire logic KEY_GN,
    input wire logic KEY_TARE,
    input wire logic KEY_UNIT,
    input wire logic KEY_PRINT,
    input wire logic KEY_RECALL,
    input wire logic KEY_DIGIT,
    input wire logic [3:0] KEY_DIGIT_VAL,
    input wire logic KEY_ENTER,
    input wire logic KEY_CLEAR,
    // Weighing datapath
    input wire logic signed [23:0] GROSS_GRAD,
    input wire logic MOTION,
    input wire logic DISP_UPDATE,
    // Configuration and status
    input wire logic [23:0] FULL_SCALE,
    input wire logic LEGAL,
    input wire logic CONV_EN,
    input wire logic CONT_MODE,
    input wire logic BIDIR,
    input wire logic RX_PRINT,
    input wire logic DUMMY_ZERO,
    input wire logic DISP_CHECK,
    input wire logic CAL_DIG,
    input wire logic CAL_ANA,
    input wire logic DATA_BAD,
    // Annunciators and results
    output logic LED_GROSS,
    output logic LED_NET,
    output logic LED_LB,
    output logic LED_KG,
    output logic LED_RECALL,
    output logic OVERLOAD,
    output logic UNDERLOAD,
    output logic ZERO_REJECT,
    output logic TARE_REJECT,
    output logic signed [23:0] DISP_WT,
    output logic signed [23:0] TARE_WT,
    output logic [19:0] ENTRY_VAL,
    // Serial line
    output logic TXD
);
    typedef struct packed {
        wsf_pkg::wsf_keys_t k1;
        wsf_pkg::wsf_keys_t k2;
        wsf_pkg::wsf_keys_t k3;
        logic [3:0] d1;
        logic [3:0] d2;
        logic signed [23:0] zoff;
        logic signed [23:0] tare;
        logic net;
        logic kg;
        logic rcl;
        logic [19:0] entry;
        logic [2:0] ecnt;
        logic ovl;
        logic unl;
        logic zrej;
        logic trej;
        logic signed [23:0] disp;
        logic [31:0] fcnt;
        logic flash;
        logic led_rcl;
        logic led_g;
        logic led_lb;
        wsf_pkg::wsf_fst_t fst;
        logic [4:0] idx;
        wsf_pkg::wsf_snap_t snap;
        logic fv;
        logic [6:0] fc;
        wsf_pkg::wsf_ust_t ust;
        logic [3:0] bcnt;
        logic [31:0] baud;
        logic [8:0] sh;
        logic txd;
    } wsf_top_st_t;
    wsf_top_st_t s_r, s_nxt;

    // Counts below two cannot time a bit or a flash
    if (BIT_CYCLES < 2 || FLASH_CYCLES < 2) begin : g_bad
        $error("bit and flash counts must be at least two");
    end

    // Double dabble to seven BCD digits
    function automatic logic [27:0] to_bcd(input logic [23:0] v);
        logic [27:0] b;
        b = '0;
        for (int i = 23; i >= 0; i--) begin
            for (int j = 0; j < 7; j++) begin
                if (b[4*j +: 4] > 4'h4) b[4*j +: 4] = b[4*j +: 4] + 4'h3;
            end
            b = {b[26:0], v[i]};
        end
        return b;
    endfunction

    // Magnitude of a signed weight
    function automatic logic [23:0] mag(input logic signed [23:0] v);
        return v < 0 ? 24'(-v) : 24'(v);
    endfunction

    // Per-mille share of full scale
    function automatic logic [23:0] pct(input logic [23:0] fs,
                                        input logic [10:0] pm);
        return 24'((36'(fs) * 36'(pm)) / 36'(`WSF_PERMIL));
    endfunction

    // Digit character, leading zeros become spaces
    function automatic logic [6:0] dchar(input logic [27:0] d,
                                         input logic [2:0] pos);
        logic lead;
        logic [3:0] dg;
        lead = 1'b1;
        dg = d[27 - 4*pos -: 4];
        for (int i = 0; i < 7; i++) begin
            if (i < pos && d[27 - 4*i -: 4] != 4'h0) lead = 1'b0;
        end
        return (lead && dg == 4'h0 && pos != 3'h6) ? `WSF_C_SP
             : `WSF_C_0 + 7'(dg);
    endfunction

    // Base pounds to kilograms
    function automatic logic signed [23:0] to_kg(input logic signed [23:0] w);
        logic signed [40:0] p;
        p = w * $signed(`WSF_KG_MUL);
        return 24'(p >>> `WSF_KG_SHIFT);
    endfunction

    // Character at a frame index; only contents go on the line
    function automatic logic [6:0] fchar(input wsf_pkg::wsf_fst_t f,
                                         input logic [4:0] i,
                                         input wsf_pkg::wsf_snap_t p);
        logic [6:0] c;
        logic [27:0] wd;
        wd = p.dz ? {p.wd[23:0], 4'h0} : p.wd;
        c = `WSF_C_SP;
        if (i == 5'h0) begin
            c = `WSF_C_STX;
        end else if (f == wsf_pkg::F_ID) begin
            case (i)
                5'h3, 5'h4, 5'h5, 5'h6, 5'h7, 5'h8:
                    c = dchar({4'h0, p.idd}, 3'(i - 5'h2));
                5'h0a: c = `WSF_C_I;
                5'h0b: c = `WSF_C_D;
                5'h0d: c = `WSF_C_N;
                5'h0e: c = `WSF_C_O;
                5'h0f: c = `WSF_C_DOT;
                5'h10: c = `WSF_C_CR;
                5'h11: c = `WSF_C_LF;
                default: c = `WSF_C_SP;
            endcase
        end else if (i == 5'h1) begin
            c = p.neg ? `WSF_C_MIN : `WSF_C_SP;
        end else if (i <= 5'h8) begin
            c = dchar(wd, 3'(i - 5'h2));
        end else if (f == wsf_pkg::F_CONT) begin
            case (i)
                5'h09: c = p.kg ? `WSF_C_K : `WSF_C_L;
                5'h0a: c = p.net ? `WSF_C_N : `WSF_C_G;
                5'h0b: c = p.stat;
                5'h0c: c = `WSF_C_CR;
                5'h0d: c = `WSF_C_LF;
                default: c = `WSF_C_SP;
            endcase
        end else begin
            case (i)
                5'h0a: c = p.kg ? `WSF_C_K : `WSF_C_L;
                5'h0b: c = p.kg ? `WSF_C_G : `WSF_C_B;
                5'h0d: c = p.net ? `WSF_C_N : `WSF_C_G;
                5'h0e: c = p.net ? `WSF_C_T : `WSF_C_R;
                5'h10: c = `WSF_C_CR;
                5'h11: c = `WSF_C_LF;
                default: c = `WSF_C_SP;
            endcase
        end
        return c;
    endfunction

    wsf_pkg::wsf_keys_t keys_in, ev;
    wsf_pkg::wsf_snap_t snap_now;
    logic signed [23:0] grel, netw, shown;
    logic [23:0] band, lim;
    logic zero_ok, tare_ok, prt, inhibit, load_ch, is_last;
    logic fifo_rdy, fifo_vld;
    logic [6:0] fifo_q, stat;
    logic [27:0] id_bcd;

    // Raw key pins gathered for the synchroniser
    assign keys_in = '{zero: KEY_ZERO, gn: KEY_GN, tare: KEY_TARE,
                       unit: KEY_UNIT, prnt: KEY_PRINT, recall: KEY_RECALL,
                       digit: KEY_DIGIT, enter: KEY_ENTER, clear: KEY_CLEAR};
    // Press edges from the synchronised stage
    assign ev = s_r.k2 & ~s_r.k3;

    // Weights relative to the captured zero and tare
    assign grel = GROSS_GRAD - s_r.zoff;
    assign netw = grel - s_r.tare;
    assign shown = s_r.rcl ? s_r.tare : (s_r.net ? netw : grel);
    assign band = pct(FULL_SCALE, `WSF_ZBAND_PM);
    assign lim = (LEGAL && s_r.zoff > 0
                  && 24'(s_r.zoff) >= pct(FULL_SCALE, `WSF_CAPT_PM))
               ? pct(FULL_SCALE, `WSF_OVL_LEGAL_PM)
               : pct(FULL_SCALE, `WSF_OVL_PM);
    assign zero_ok = mag(grel) <= band && !MOTION
                     && !s_r.ovl && !s_r.unl;
    assign tare_ok = !s_r.net && grel > 0 && !MOTION;
    assign prt = ev.prnt || (RX_PRINT && BIDIR);
    assign inhibit = MOTION || s_r.ovl || s_r.unl || DISP_CHECK || s_r.rcl
                     || (!s_r.net && grel < 0);

    // Status character, highest priority first
    assign stat = CAL_DIG ? `WSF_C_D : CAL_ANA ? `WSF_C_A
                : DATA_BAD ? `WSF_C_I : (s_r.ovl || s_r.unl) ? `WSF_C_O
                : MOTION ? `WSF_C_M : s_r.rcl ? `WSF_C_Z
                : `WSF_C_SP;
    assign snap_now = '{neg: s_r.disp < 0, kg: s_r.kg, net: s_r.net,
                        dz: DUMMY_ZERO, stat: stat,
                        wd: to_bcd(mag(s_r.disp)),
                        idd: id_bcd[23:0]};
    assign id_bcd = to_bcd(24'(s_r.entry));

    // Next character goes out when the holding slot frees
    assign load_ch = s_r.fst != wsf_pkg::F_IDLE && (!s_r.fv || fifo_rdy);
    assign is_last = s_r.idx == (s_r.fst == wsf_pkg::F_CONT
                                 ? `WSF_LAST_CONT : `WSF_LAST_DEM);

    wsf_fifo #(
        .W(7),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clk(CLK),
        .rst_b(RST_B),
        .in_valid(s_r.fv),
        .in_data(s_r.fc),
        .in_ready(fifo_rdy),
        .out_valid(fifo_vld),
        .out_data(fifo_q),
        .out_ready(s_r.ust == wsf_pkg::U_IDLE)
    );

    // Next state of the whole block
    always_comb begin
        s_nxt = s_r;
        s_nxt.k1 = keys_in;
        s_nxt.k2 = s_r.k1;
        s_nxt.k3 = s_r.k2;
        s_nxt.d1 = KEY_DIGIT_VAL;
        s_nxt.d2 = s_r.d1;
        s_nxt.zrej = 1'b0;
        s_nxt.trej = 1'b0;
        s_nxt.kg = s_r.kg && CONV_EN;
        s_nxt.ovl = grel > 0 && 24'(grel) > lim;
        s_nxt.unl = grel < -$signed(`WSF_UNDER_GRAD);
        s_nxt.disp = s_r.kg ? to_kg(shown) : shown;
        // Front-panel keys
        if (ev.zero) begin
            if (zero_ok) s_nxt.zoff = s_r.zoff + grel;
            else s_nxt.zrej = 1'b1;
        end
        if (ev.gn) begin
            s_nxt.net = !s_r.net;
            s_nxt.rcl = 1'b0;
        end
        if (ev.tare) begin
            if (tare_ok) begin
                s_nxt.tare = grel;
                s_nxt.net = 1'b1;
            end else begin
                s_nxt.trej = 1'b1;
            end
        end
        if (ev.unit && CONV_EN) s_nxt.kg = !s_r.kg;
        if (ev.recall) s_nxt.rcl = !s_r.rcl;
        if (ev.digit && s_r.ecnt < `WSF_ENT_MAX) begin
            s_nxt.entry = s_r.entry * 20'ha + 20'(s_r.d2);
            s_nxt.ecnt = s_r.ecnt + 3'h1;
        end
        if (ev.enter && s_r.net) begin
            s_nxt.tare = 24'(s_r.entry);
            s_nxt.entry = '0;
            s_nxt.ecnt = '0;
        end
        if (ev.clear) begin
            s_nxt.entry = '0;
            s_nxt.ecnt = '0;
        end
        // Recall lamp flash
        s_nxt.fcnt = s_r.fcnt + 32'h1;
        if (s_r.fcnt == 32'(FLASH_CYCLES - 1)) begin
            s_nxt.fcnt = '0;
            s_nxt.flash = !s_r.flash;
        end
        // Frame builder
        if (s_r.fv && fifo_rdy) s_nxt.fv = 1'b0;
        case (s_r.fst)
            wsf_pkg::F_IDLE: begin
                s_nxt.idx = '0;
                if (prt && !inhibit) begin
                    s_nxt.snap = snap_now;
                    if (s_r.ecnt != 3'h0 && !s_r.net) begin
                        s_nxt.fst = wsf_pkg::F_ID;
                        s_nxt.entry = '0;
                        s_nxt.ecnt = '0;
                    end else begin
                        s_nxt.fst = wsf_pkg::F_DEM;
                    end
                end else if (DISP_UPDATE && CONT_MODE) begin
                    s_nxt.snap = snap_now;
                    s_nxt.fst = wsf_pkg::F_CONT;
                end
            end
            default: begin
                if (load_ch) begin
                    s_nxt.fv = 1'b1;
                    s_nxt.fc = fchar(s_r.fst, s_r.idx, s_r.snap);
                    s_nxt.idx = s_r.idx + 5'h1;
                    if (is_last) begin
                        s_nxt.idx = '0;
                        s_nxt.fst = s_r.fst == wsf_pkg::F_ID
                                  ? wsf_pkg::F_DEM : wsf_pkg::F_IDLE;
                    end
                end
            end
        endcase
        // Serial sender
        case (s_r.ust)
            wsf_pkg::U_IDLE: begin
                if (fifo_vld) begin
                    s_nxt.ust = wsf_pkg::U_SEND;
                    s_nxt.txd = 1'b0;
                    s_nxt.bcnt = '0;
                    s_nxt.baud = '0;
                    s_nxt.sh = {1'b1, ~^fifo_q, fifo_q};
                end
            end
            default: begin
                s_nxt.baud = s_r.baud + 32'h1;
                if (s_r.baud == 32'(BIT_CYCLES - 1)) begin
                    s_nxt.baud = '0;
                    if (s_r.bcnt == `WSF_STOP_BIT) begin
                        s_nxt.ust = wsf_pkg::U_IDLE;
                        s_nxt.txd = 1'b1;
                    end else begin
                        s_nxt.txd = s_r.sh[0];
                        s_nxt.sh = {1'b1, s_r.sh[8:1]};
                        s_nxt.bcnt = s_r.bcnt + 4'h1;
                    end
                end
            end
        endcase
        s_nxt.led_rcl = s_nxt.rcl && s_nxt.flash;
        s_nxt.led_g = !s_nxt.net;
        s_nxt.led_lb = !s_nxt.kg;
    end

    // State register; gross mode and idle line after reset
    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            s_r <= '0;
            s_r.fst <= wsf_pkg::F_IDLE;
            s_r.ust <= wsf_pkg::U_IDLE;
            s_r.txd <= 1'b1;
            s_r.led_g <= 1'b1;
            s_r.led_lb <= 1'b1;
        end else begin
            s_r <= s_nxt;
        end
    end

    // Outputs
    assign LED_GROSS = s_r.led_g;
    assign LED_NET = s_r.net;
    assign LED_LB = s_r.led_lb;
    assign LED_KG = s_r.kg;
    assign LED_RECALL = s_r.led_rcl;
    assign OVERLOAD = s_r.ovl;
    assign UNDERLOAD = s_r.unl;
    assign ZERO_REJECT = s_r.zrej;
    assign TARE_REJECT = s_r.trej;
    assign DISP_WT = s_r.disp;
    assign TARE_WT = s_r.tare;
    assign ENTRY_VAL = s_r.entry;
    assign TXD = s_r.txd;

    // Checks
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RST_B);

    gross_after_reset_a: assert property ($rose(RST_B) |-> LED_GROSS)
        else $error("not gross after reset");
    lamp_pairs_a: assert property (LED_GROSS != LED_NET
                                   && LED_LB != LED_KG)
        else $error("annunciator pair inconsistent");
    zero_refused_a: assert property (ev.zero && MOTION |=> ZERO_REJECT
                                     && $stable(s_r.zoff))
        else $error("zero taken while moving");
    zero_taken_a: assert property (ev.zero && zero_ok |=>
                                   s_r.zoff == $past(s_r.zoff) + $past(grel))
        else $error("zero not captured");
    tare_net_a: assert property (ev.tare && tare_ok && !ev.gn
                                 |=> LED_NET && TARE_WT == $past(grel))
        else $error("tare not applied");
    tare_kept_a: assert property (ev.tare && !tare_ok && !ev.gn
                                  && !ev.enter |=> $stable(TARE_WT)
                                  && $stable(LED_NET))
        else $error("refused tare altered state");
    over_flag_a: assert property (grel > 0 && 24'(grel) > lim
                                  |=> OVERLOAD)
        else $error("overload missed");
    under_flag_a: assert property (grel < -$signed(`WSF_UNDER_GRAD)
                                   |=> UNDERLOAD)
        else $error("underload missed");
    demand_block_a: assert property (s_r.fst == wsf_pkg::F_IDLE
                                     && inhibit && !CONT_MODE
                                     |=> s_r.fst == wsf_pkg::F_IDLE)
        else $error("demand frame not suppressed");
    stx_first_a: assert property (load_ch && s_r.idx == 5'h0
                                  |=> s_r.fc == `WSF_C_STX)
        else $error("frame not opened by start of text");

    sequence lf_load_s;
        load_ch && is_last && s_r.fst != wsf_pkg::F_ID;
    endsequence
    sequence cr_lf_s;
        s_r.fc == `WSF_C_CR ##1 s_r.fc == `WSF_C_LF;
    endsequence
    frame_tail_a: assert property (lf_load_s |-> cr_lf_s)
        else $error("frame tail not CR LF");

    sequence char_start_s;
        s_r.ust == wsf_pkg::U_IDLE && fifo_vld;
    endsequence
    start_parity_a: assert property (char_start_s |=> !TXD
                                     && ^s_r.sh[7:0])
        else $error("bad start bit or parity");
    stop_bit_a: assert property (s_r.ust == wsf_pkg::U_SEND
                                 && s_r.bcnt == `WSF_STOP_BIT |-> TXD)
        else $error("stop bit low");
endmodule

/* File: verification/wsf_rx_model.sv */
// Serial printer model that decodes characters from the line.
// Assumes the line idles high and one bit lasts BC clocks.
`timescale 1ns/1ps
module wsf_rx_model #(
    parameter int BC = 4
) (
    // Clock and line
    input wire logic clk,
    input wire logic rxd,
    // Decoded character
    output logic [6:0] ch,
    output logic got,
    output logic bad
);
    logic [8:0] sh;
    // Sample mid-bit: data LSB first, parity, stop
    initial begin
        got = 1'b0;
        bad = 1'b0;
        ch = 7'h00;
        forever begin
            @(negedge rxd);
            repeat (BC / 2) @(posedge clk);
            for (int i = 0; i < 9; i++) begin
                repeat (BC) @(posedge clk);
                sh[i] = rxd;
            end
            ch = sh[6:0];
            bad = !(^sh[7:0]) || !sh[8];
            got = 1'b1;
            @(posedge clk);
            got = 1'b0;
        end
    end
endmodule

/* File: verification/tb_top.sv */
// Bench for the weigh mode block and its serial frames.
// Assumes a short bit time and the printer model on TXD.
`timescale 1ns/1ps
`define CHK(n, e, g) begin n_compared++; if ((e) !== (g)) begin errors++; \
    $display("BAD %s exp %0h got %0h", n, e, g); end end
module tb_top;
    logic clk, rst_b, upd, mot, conv, cont, bidir, rxp, got, bad, txd;
    logic led_g, led_n, led_lb, led_kg, ovl, unl;
    logic legal, dzero, dchk, cdig, cana, dbad;
    logic signed [23:0] gross, tare, dw;
    logic [23:0] fs;
    logic [3:0] dv;
    logic [6:0] ch;
    logic [6:0] q[$];
    wsf_pkg::wsf_keys_t k;
    int errors = 0;
    int n_compared = 0;
    // Clock
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    wsf_top #(.BIT_CYCLES(4), .FLASH_CYCLES(8)) u_wsf_top (.CLK(clk),
        .RST_B(rst_b), .KEY_ZERO(k.zero), .KEY_GN(k.gn), .KEY_TARE(k.tare),
        .KEY_UNIT(k.unit), .KEY_PRINT(k.prnt), .KEY_RECALL(k.recall),
        .KEY_DIGIT(k.digit), .KEY_DIGIT_VAL(dv), .KEY_ENTER(k.enter),
        .KEY_CLEAR(k.clear), .GROSS_GRAD(gross), .MOTION(mot),
        .DISP_UPDATE(upd), .FULL_SCALE(fs), .LEGAL(legal), .CONV_EN(conv),
        .CONT_MODE(cont), .BIDIR(bidir), .RX_PRINT(rxp), .DUMMY_ZERO(dzero),
        .DISP_CHECK(dchk), .CAL_DIG(cdig), .CAL_ANA(cana), .DATA_BAD(dbad),
        .LED_GROSS(led_g), .LED_NET(led_n), .LED_LB(led_lb), .LED_KG(led_kg),
        .LED_RECALL(), .OVERLOAD(ovl), .UNDERLOAD(unl), .ZERO_REJECT(),
        .TARE_REJECT(), .DISP_WT(dw), .TARE_WT(tare), .ENTRY_VAL(), .TXD(txd));
    wsf_rx_model #(.BC(4)) u_wsf_rx_model (.clk(clk), .rxd(txd), .ch(ch),
        .got(got), .bad(bad));
    // Collect received characters
    always @(posedge got) begin
        q.push_back(ch);
        `CHK("parity", 1'b0, bad)
    end
    task automatic press(input wsf_pkg::wsf_keys_t m);
        k <= m;
        repeat (4) @(posedge clk);
        k <= '0;
        repeat (6) @(posedge clk);
    endtask
    task automatic pulse_upd;
        @(posedge clk);
        upd <= 1'b1;
        @(posedge clk);
        upd <= 1'b0;
    endtask
    task automatic frame(input string s);
        byte b;
        for (int i = 0; i < 3000 && q.size() < s.len(); i++) @(posedge clk);
        repeat (60) @(posedge clk);
        `CHK("len", s.len(), q.size())
        for (int i = 0; i < s.len() && i < q.size(); i++) begin
            b = s[i];
            `CHK("char", b[6:0], q[i])
        end
        q = {};
    endtask
    task automatic t_reset;
        `CHK("gross_led", 1'b1, led_g)
        `CHK("lb_led", 1'b1, led_lb)
    endtask
    task automatic t_cont;
        cont <= 1'b1;
        pulse_upd();
        frame("\002     123LG \015\012");
        mot <= 1'b1;
        pulse_upd();
        frame("\002     123LGM\015\012");
        {dzero, dbad} <= 2'b11;
        pulse_upd();
        frame("\002    1230LGI\015\012");
        {mot, dzero, dbad} <= 3'b000;
    endtask
    task automatic t_zero;
        gross <= 24'h00000a;
        press(9'h100);
        `CHK("disp", 24'h000000, dw)
        gross <= 24'h00001e;
        press(9'h100);
        `CHK("disp", 24'h000014, dw)
    endtask
    task automatic t_tare;
        press(9'h040);
        `CHK("tare", 24'h00007b, tare)
        `CHK("net_led", 1'b1, led_n)
        gross <= 24'h0000c8;
        pulse_upd();
        frame("\002      77LN \015\012");
        press(9'h080);
        `CHK("gross_led", 1'b1, led_g)
        mot <= 1'b1;
        press(9'h040);
        `CHK("tare", 24'h00007b, tare)
        `CHK("gross_led", 1'b1, led_g)
        mot <= 1'b0;
    endtask
    task automatic t_unit;
        conv <= 1'b1;
        press(9'h020);
        `CHK("kg_led", 1'b1, led_kg)
        pulse_upd();
        frame("\002      90KG \015\012");
        press(9'h020);
        `CHK("lb_led", 1'b1, led_lb)
        cont <= 1'b0;
    endtask
    task automatic t_demand;
        press(9'h010);
        frame("\002     200 LB GR \015\012");
        bidir <= 1'b1;
        rxp <= 1'b1;
        @(posedge clk);
        rxp <= 1'b0;
        frame("\002     200 LB GR \015\012");
        mot <= 1'b1;
        press(9'h010);
        frame("");
        {mot, dchk} <= 2'b01;
        press(9'h010);
        frame("");
        dchk <= 1'b0;
    endtask
    task automatic t_range(input logic [23:0] g, input logic o, input logic u);
        gross <= g;
        repeat (3) @(posedge clk);
        `CHK("over", o, ovl)
        `CHK("under", u, unl)
    endtask
    task automatic tally_and_finish;
        $display("errors %0d compared %0d", errors, n_compared);
        if (errors == 0 && n_compared > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    // Watchdog
    initial begin
        repeat (20000) @(posedge clk);
        errors++;
        tally_and_finish();
    end
    // Main sequence
    initial begin
        {rst_b, upd, mot, conv, cont, bidir, rxp} = '0;
        {legal, dzero, dchk, cdig, cana, dbad} = '0;
        k = '0;
        dv = 4'h0;
        gross = 24'h00007b;
        fs = 24'h0003e8;
        repeat (2) @(posedge clk);
        rst_b <= 1'b1;
        @(posedge clk);
        t_reset();
        t_cont();
        t_tare();
        t_unit();
        t_demand();
        t_range(24'h00041b, 1'b1, 1'b0);
        t_range(24'h00041a, 1'b0, 1'b0);
        t_range(24'hfffe6f, 1'b0, 1'b1);
        t_range(24'hfffe70, 1'b0, 1'b0);
        t_zero();
        tally_and_finish();
    end
endmodule
